/* hdl/add_carry_alu_params.svh */
// Register map, field positions, reset values and flag bits
`ifndef ADD_CARRY_ALU_PARAMS_SVH
`define ADD_CARRY_ALU_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define CTRL_OFS 8'h00
`define LIT_OFS 8'h04
`define FLAGS_OFS 8'h08
`define RESULT_OFS 8'h0c
`define STATUS_OFS 8'h10
`define MASK_OFS 8'h14
`define FILE_BASE 3'h1

// ****************************************
// Field positions
// ****************************************
`define CTRL_OP_LSB 0
`define CTRL_BYTE 2
`define CTRL_LIT 3
`define CTRL_SRC_LSB 4
`define CTRL_DST_LSB 7
`define CTRL_DST_SP 10
`define CTRL_FMT_LSB 11
`define CTRL_GO 31
`define FLG_C 0
`define FLG_D 1
`define FLG_Z 2
`define FLG_S 3
`define FLG_B 4
`define FLG_O 5
`define FLG_I 6
`define FLG_U 7
`define ST_DONE 0
`define ST_ILLEGAL 1
`define ST_BUSY 8

// ****************************************
// Reset values, indices and answers
// ****************************************
`define FLAGS_RST 8'h00
`define MASK_RST 2'h0
`define USP_IDX 3'h6
`define ISP_IDX 3'h7
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define RESP_DECERR 2'h3
`define READ_LATENCY 2

`endif

/* hdl/alu_types_pkg.sv */
// Types shared by the add-with-carry datapath modules
package alu_types_pkg;

  typedef enum logic [1:0] {OP_ADC, OP_CARRY_INC, OP_ADD, OP_RSVD} op_t;
  typedef enum logic [1:0] {FMT_GENERIC, FMT_QUICK, FMT_SHORT,
    FMT_RSVD} fmt_t;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_FETCH_SRC, SEQ_FETCH_DST,
    SEQ_EXEC} seq_t;

  typedef struct packed {
    op_t op;
    fmt_t fmt;
    logic dst_sp;
    logic [2:0] dst_idx;
    logic [2:0] src_idx;
    logic lit;
    logic byte_sz;
  } cmd_t;

  typedef struct packed {
    logic [7:0][15:0] words;
    logic [15:0] rd_data;
  } store_t;

  typedef struct packed {
    seq_t seq;
    cmd_t cmd;
    logic [15:0] lit;
    logic [7:0] flags;
    logic [15:0] result;
    logic [1:0] status;
    logic [1:0] mask;
    logic irq;
    logic go_pend;
    logic [15:0] src_word;
    logic aw_held;
    logic [7:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic [1:0] rd_stage;
    logic [7:0] araddr;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ctl_state_t;

endpackage : alu_types_pkg

/* hdl/alu_op_if.sv */
// Operand and flag bundle between sequencer and adder
interface alu_op_if;
  logic [15:0] a;
  logic [15:0] b;
  logic cin;
  logic wide;
  logic [15:0] sum;
  logic ovf;
  logic neg;
  logic zero;
  logic cry;
  modport requester (output a, b, cin, wide, input sum, ovf, neg, zero, cry);
  modport adder (input a, b, cin, wide, output sum, ovf, neg, zero, cry);
endinterface : alu_op_if

/* hdl/flag_adder.sv */
// Byte or word adder with overflow, sign, zero and carry
module flag_adder (
  alu_op_if.adder bus
);

  logic [16:0] full;
  logic [8:0] low;
  logic msb_a;
  logic msb_b;
  logic msb_r;

  always_comb begin
    full = {1'b0, bus.a} + {1'b0, bus.b} + {16'h0000, bus.cin};
    low = {1'b0, bus.a[7:0]} + {1'b0, bus.b[7:0]} + {8'h00, bus.cin};
    bus.sum = bus.wide ? full[15:0] : {8'h00, low[7:0]};
    msb_a = bus.wide ? bus.a[15] : bus.a[7];
    msb_b = bus.wide ? bus.b[15] : bus.b[7];
    msb_r = bus.wide ? full[15] : low[7];
    // Carry in cannot overflow operands of opposite sign
    bus.ovf = (msb_a == msb_b) && (msb_r != msb_a);
    bus.neg = msb_r;
    bus.zero = bus.wide ? (full[15:0] == 16'h0000) : (low[7:0] == 8'h00);
    bus.cry = bus.wide ? full[16] : low[8];
  end

endmodule : flag_adder

/* hdl/operand_store.sv */
// Eight-word operand store with registered read data
module operand_store (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [2:0] rd_addr,
  output logic [15:0] rd_data,
  input wire logic wr_en,
  input wire logic [2:0] wr_addr,
  input wire logic [15:0] wr_data
);

  alu_types_pkg::store_t st;
  alu_types_pkg::store_t nx;

  always_comb begin
    nx = st;
    nx.rd_data = st.words[rd_addr];
    if (wr_en) begin
      nx.words[wr_addr] = wr_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign rd_data = st.rd_data;

endmodule : operand_store

/* hdl/add_carry_alu.sv */
// Add-with-carry datapath slice with AXI4-Lite register access
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`include "add_carry_alu_params.svh"
module add_carry_alu (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic irq
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic is_areg(input logic [2:0] idx);
    return idx[2:1] == 2'b10;
  endfunction : is_areg

  // Byte registers pair up: even index low half, odd index high half
  function automatic logic [2:0] word_idx(input logic [2:0] idx,
                                          input logic byte_sz);
    return (byte_sz && !idx[2]) ? {2'b00, idx[1]} : idx;
  endfunction : word_idx

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  function automatic logic [31:0] ctrl_word(input alu_types_pkg::cmd_t c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`CTRL_OP_LSB +: 2] = c.op;
    w[`CTRL_BYTE] = c.byte_sz;
    w[`CTRL_LIT] = c.lit;
    w[`CTRL_SRC_LSB +: 3] = c.src_idx;
    w[`CTRL_DST_LSB +: 3] = c.dst_idx;
    w[`CTRL_DST_SP] = c.dst_sp;
    w[`CTRL_FMT_LSB +: 2] = c.fmt;
    return w;
  endfunction : ctrl_word

  function automatic alu_types_pkg::cmd_t to_cmd(input logic [31:0] w);
    alu_types_pkg::cmd_t c;
    c.op = alu_types_pkg::op_t'(w[`CTRL_OP_LSB +: 2]);
    c.byte_sz = w[`CTRL_BYTE];
    c.lit = w[`CTRL_LIT];
    c.src_idx = w[`CTRL_SRC_LSB +: 3];
    c.dst_idx = w[`CTRL_DST_LSB +: 3];
    c.dst_sp = w[`CTRL_DST_SP];
    c.fmt = alu_types_pkg::fmt_t'(w[`CTRL_FMT_LSB +: 2]);
    return c;
  endfunction : to_cmd

  // ****************************************
  // State and submodules
  // ****************************************
  alu_types_pkg::ctl_state_t st;
  alu_types_pkg::ctl_state_t nx;
  alu_types_pkg::cmd_t cmd;
  logic [2:0] mem_rd_addr;
  logic [15:0] mem_rd_data;
  logic mem_wr_en;
  logic [2:0] mem_wr_addr;
  logic [15:0] mem_wr_data;
  logic [2:0] src_phys;
  logic [2:0] dst_phys;
  logic [15:0] lit_val;
  logic [7:0] src_byte;
  logic [7:0] dst_byte;
  logic [15:0] dst_word;
  logic [15:0] wb_word;
  logic dst_hi;
  logic wide;
  logic bad_cmd;
  logic busy;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic ovf_ref;
  logic cry_ref;
  logic [31:0] wmerge;
  int ref_u;
  int ref_s;

  alu_op_if ops ();

  flag_adder u_adder (
    .bus(ops)
  );

  operand_store u_store (
    .aclk(aclk),
    .aresetn(aresetn),
    .rd_addr(mem_rd_addr),
    .rd_data(mem_rd_data),
    .wr_en(mem_wr_en),
    .wr_addr(mem_wr_addr),
    .wr_data(mem_wr_data)
  );

  // ****************************************
  // Operand preparation
  // ****************************************
  assign cmd = st.cmd;
  assign dst_word = mem_rd_data;
  assign src_phys = word_idx(cmd.src_idx, cmd.byte_sz);
  assign dst_phys = cmd.dst_sp ? (st.flags[`FLG_U] ? `USP_IDX : `ISP_IDX) :
                    word_idx(cmd.dst_idx, cmd.byte_sz);
  assign lit_val = (cmd.fmt == alu_types_pkg::FMT_QUICK) ?
                   {{12{st.lit[3]}}, st.lit[3:0]} : st.lit;
  assign src_byte = cmd.lit ? lit_val[7:0] :
                    (is_areg(cmd.src_idx) || !cmd.src_idx[0]) ?
                    st.src_word[7:0] : st.src_word[15:8];
  assign dst_hi = cmd.byte_sz && !cmd.dst_sp && !cmd.dst_idx[2] &&
                  cmd.dst_idx[0];
  assign dst_byte = dst_hi ? dst_word[15:8] : dst_word[7:0];
  assign wide = !cmd.byte_sz || cmd.dst_sp || is_areg(cmd.dst_idx);
  assign busy = (st.seq != alu_types_pkg::SEQ_IDLE) || st.go_pend;

  // Encodings the instruction stream must never produce
  assign bad_cmd = (cmd.byte_sz && !cmd.lit && !cmd.dst_sp &&
                    is_areg(cmd.src_idx) && is_areg(cmd.dst_idx)) ||
                   (cmd.dst_sp && !cmd.lit) ||
                   (cmd.fmt == alu_types_pkg::FMT_QUICK && !cmd.lit) ||
                   (cmd.fmt == alu_types_pkg::FMT_SHORT &&
                    !cmd.byte_sz) ||
                   (cmd.fmt == alu_types_pkg::FMT_SHORT && !cmd.lit &&
                    !cmd.dst_sp && cmd.src_idx == cmd.dst_idx) ||
                   (!cmd.lit && cmd.src_idx[2:1] == 2'b11) ||
                   (!cmd.dst_sp && cmd.dst_idx[2:1] == 2'b11) ||
                   cmd.fmt == alu_types_pkg::FMT_RSVD ||
                   cmd.op == alu_types_pkg::OP_RSVD;

  always_comb begin
    if (cmd.op == alu_types_pkg::OP_CARRY_INC) begin
      ops.a = 16'h0000;
    end else if (!cmd.byte_sz) begin
      ops.a = cmd.lit ? lit_val : st.src_word;
    end else if (cmd.dst_sp) begin
      ops.a = {{8{src_byte[7]}}, src_byte};
    end else begin
      ops.a = {8'h00, src_byte};
    end
    ops.b = wide ? dst_word : {8'h00, dst_byte};
    // Only plain add runs without the carry input
    ops.cin = (cmd.op == alu_types_pkg::OP_ADD) ? 1'b0 :
              st.flags[`FLG_C];
    ops.wide = wide;
    if (wide) begin
      wb_word = ops.sum;
    end else if (dst_hi) begin
      wb_word = {ops.sum[7:0], dst_word[7:0]};
    end else begin
      wb_word = {dst_word[15:8], ops.sum[7:0]};
    end
  end

  // ****************************************
  // Sequencer and register slave
  // ****************************************
  assign aw_take = awvalid && st.awready;
  assign w_take = wvalid && st.wready;
  assign ar_take = arvalid && st.arready;

  always_comb begin
    nx = st;
    wmerge = 32'h0000_0000;
    mem_wr_en = 1'b0;
    mem_wr_addr = dst_phys;
    mem_wr_data = wb_word;
    if (st.rd_stage == 2'd1) begin
      mem_rd_addr = st.araddr[4:2];
    end else if (st.seq == alu_types_pkg::SEQ_FETCH_SRC) begin
      mem_rd_addr = src_phys;
    end else begin
      mem_rd_addr = dst_phys;
    end
    case (st.seq)
      alu_types_pkg::SEQ_IDLE: begin
        // A pending read owns the store port, so the start waits
        if (st.go_pend && st.rd_stage == 2'd0) begin
          nx.go_pend = 1'b0;
          if (bad_cmd) begin
            nx.status[`ST_ILLEGAL] = 1'b1;
          end else begin
            nx.seq = alu_types_pkg::SEQ_FETCH_SRC;
          end
        end
      end
      alu_types_pkg::SEQ_FETCH_SRC: begin
        nx.seq = alu_types_pkg::SEQ_FETCH_DST;
      end
      alu_types_pkg::SEQ_FETCH_DST: begin
        nx.src_word = mem_rd_data;
        nx.seq = alu_types_pkg::SEQ_EXEC;
      end
      alu_types_pkg::SEQ_EXEC: begin
        mem_wr_en = 1'b1;
        nx.result = ops.sum;
        nx.flags[`FLG_O] = ops.ovf;
        nx.flags[`FLG_S] = ops.neg;
        nx.flags[`FLG_Z] = ops.zero;
        nx.flags[`FLG_C] = ops.cry;
        nx.status[`ST_DONE] = 1'b1;
        nx.seq = alu_types_pkg::SEQ_IDLE;
      end
      default: begin
        nx.seq = alu_types_pkg::SEQ_IDLE;
      end
    endcase

    if (st.bvalid && bready) begin
      nx.bvalid = 1'b0;
    end
    if (aw_take) begin
      nx.aw_held = 1'b1;
      nx.awaddr = awaddr;
    end
    if (w_take) begin
      nx.w_held = 1'b1;
      nx.wdata = wdata;
      nx.wstrb = wstrb;
    end
    if (st.aw_held && st.w_held && !st.bvalid) begin
      nx.aw_held = 1'b0;
      nx.w_held = 1'b0;
      nx.bvalid = 1'b1;
      nx.bresp = busy ? `RESP_SLVERR : `RESP_OKAY;
      case (st.awaddr)
        `CTRL_OFS: begin
          if (!busy) begin
            nx.cmd = to_cmd(merge(ctrl_word(cmd), st.wdata, st.wstrb));
            nx.go_pend = st.wstrb[3] && st.wdata[`CTRL_GO];
          end
        end
        `LIT_OFS: begin
          if (!busy) begin
            wmerge = merge({16'h0000, st.lit}, st.wdata, st.wstrb);
            nx.lit = wmerge[15:0];
          end
        end
        `FLAGS_OFS: begin
          if (!busy) begin
            wmerge = merge({24'h0, st.flags}, st.wdata, st.wstrb);
            nx.flags = wmerge[7:0];
          end
        end
        `MASK_OFS: begin
          nx.mask = merge({30'h0, st.mask}, st.wdata, st.wstrb)[1:0];
          nx.bresp = `RESP_OKAY;
        end
        `RESULT_OFS, `STATUS_OFS: begin
          nx.bresp = `RESP_OKAY;
        end
        default: begin
          if (st.awaddr[7:5] != `FILE_BASE) begin
            nx.bresp = `RESP_DECERR;
          end else if (!busy) begin
            mem_wr_en = 1'b1;
            mem_wr_addr = st.awaddr[4:2];
            mem_wr_data[15:8] = st.wstrb[1] ? st.wdata[15:8] : 8'h00;
            mem_wr_data[7:0] = st.wstrb[0] ? st.wdata[7:0] : 8'h00;
          end
        end
      endcase
    end

    if (st.rvalid && rready) begin
      nx.rvalid = 1'b0;
    end
    if (ar_take) begin
      nx.araddr = araddr;
      nx.rd_stage = 2'd1;
    end else if (st.rd_stage == 2'd1) begin
      nx.rd_stage = 2'd2;
    end else if (st.rd_stage == 2'd2) begin
      nx.rd_stage = 2'd0;
      nx.rvalid = 1'b1;
      nx.rresp = `RESP_OKAY;
      case (st.araddr)
        `CTRL_OFS: nx.rdata = ctrl_word(cmd);
        `LIT_OFS: nx.rdata = {16'h0000, st.lit};
        `FLAGS_OFS: nx.rdata = {24'h0, st.flags};
        `RESULT_OFS: nx.rdata = {16'h0000, st.result};
        `STATUS_OFS: begin
          nx.rdata = {23'h0, busy, 6'h0, st.status};
          // Clear first so an event landing now still sets its bit
          nx.status = nx.status & ~st.status;
          if (st.seq == alu_types_pkg::SEQ_EXEC) begin
            nx.status[`ST_DONE] = 1'b1;
          end
        end
        `MASK_OFS: nx.rdata = {30'h0, st.mask};
        default: begin
          if (st.araddr[7:5] == `FILE_BASE) begin
            nx.rdata = {16'h0000, mem_rd_data};
          end else begin
            nx.rdata = 32'h0000_0000;
            nx.rresp = `RESP_DECERR;
          end
        end
      endcase
    end

    nx.irq = |(nx.status & nx.mask);
    nx.awready = !nx.aw_held;
    nx.wready = !nx.w_held;
    nx.arready = nx.seq == alu_types_pkg::SEQ_IDLE && !nx.go_pend &&
                 nx.rd_stage == 2'd0 && !nx.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.flags <= `FLAGS_RST;
      st.mask <= `MASK_RST;
    end else begin
      st <= nx;
    end
  end

  assign awready = st.awready;
  assign wready = st.wready;
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign arready = st.arready;
  assign rvalid = st.rvalid;
  assign rdata = st.rdata;
  assign rresp = st.rresp;
  assign irq = st.irq;

  // ****************************************
  // Checks
  // ****************************************
  always_comb begin
    ref_u = wide ? int'(ops.a) + int'(ops.b) + int'(ops.cin) :
            int'(ops.a[7:0]) + int'(ops.b[7:0]) + int'(ops.cin);
    ref_s = wide ?
            int'($signed(ops.a)) + int'($signed(ops.b)) + int'(ops.cin) :
            int'($signed(ops.a[7:0])) + int'($signed(ops.b[7:0])) +
            int'(ops.cin);
    ovf_ref = wide ? (ref_s > 32'sh7fff || ref_s < -32'sh8000) :
              (ref_s > 32'sh7f || ref_s < -32'sh80);
    cry_ref = wide ? (ref_u > 32'hffff) : (ref_u > 32'hff);
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_ovf_range: assert property (
    st.seq == alu_types_pkg::SEQ_EXEC |=> st.flags[`FLG_O] == $past(ovf_ref))
    else $error("overflow flag disagrees with signed range");
  a_sign_msb: assert property (
    st.seq == alu_types_pkg::SEQ_EXEC |=>
      st.flags[`FLG_S] == ($past(wide) ? st.result[15] : st.result[7]))
    else $error("sign flag not result msb");
  a_zero_result: assert property (
    st.seq == alu_types_pkg::SEQ_EXEC |=>
      st.flags[`FLG_Z] == (st.result == 16'h0000))
    else $error("zero flag disagrees with result");
  a_carry_limit: assert property (
    st.seq == alu_types_pkg::SEQ_EXEC |=> st.flags[`FLG_C] == $past(cry_ref))
    else $error("carry flag disagrees with unsigned limit");
  a_areg_zero_ext: assert property (
    st.seq == alu_types_pkg::SEQ_EXEC && cmd.byte_sz && !cmd.dst_sp &&
    is_areg(cmd.dst_idx) |-> wide && ops.a[15:8] == 8'h00)
    else $error("byte source into address register not zero-extended");
  a_sp_sign_ext: assert property (
    st.seq == alu_types_pkg::SEQ_EXEC && cmd.byte_sz && cmd.dst_sp &&
    cmd.op == alu_types_pkg::OP_ADD |-> wide && ops.a[15:8] == {8{ops.a[7]}})
    else $error("stack pointer source not sign-extended");
  a_sp_literal: assert property (
    st.seq == alu_types_pkg::SEQ_IDLE && st.go_pend && st.rd_stage == 2'd0 &&
    cmd.dst_sp && !cmd.lit |=>
      st.seq == alu_types_pkg::SEQ_IDLE && st.status[`ST_ILLEGAL])
    else $error("register source to stack pointer was executed");
  a_flags_kept: assert property (
    st.seq == alu_types_pkg::SEQ_EXEC |=>
      {st.flags[`FLG_U], st.flags[`FLG_I], st.flags[`FLG_B], st.flags[`FLG_D]}
      == $past({st.flags[`FLG_U], st.flags[`FLG_I], st.flags[`FLG_B],
                st.flags[`FLG_D]}))
    else $error("control flags changed by addition");
  a_exec_timing: assert property (
    st.seq == alu_types_pkg::SEQ_FETCH_SRC |=>
      st.seq == alu_types_pkg::SEQ_FETCH_DST ##1
      st.seq == alu_types_pkg::SEQ_EXEC ##1 st.status[`ST_DONE])
    else $error("operation did not finish in three cycles");
  a_read_latency: assert property (
    arvalid && arready |-> !rvalid ##3 rvalid)
    else $error("read answer not three cycles after address");
  a_irq_level: assert property (irq == |(st.status & st.mask))
    else $error("interrupt does not match masked status");

endmodule : add_carry_alu

/* verification/testbench.sv */
// Self-checking bench for the add-with-carry datapath slice
`include "add_carry_alu_params.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  fails++; $display("unexpected %s exp %h got %h", n, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  int fails = 0;
  int cmp_count = 0;

  add_carry_alu dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .irq(irq));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // ****************************************
  // Bus cycles and helpers
  // ****************************************
  task automatic close_out;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic tmo(input int n);
    if (n >= 50) begin
      fails++;
      close_out();
    end
  endtask : tmo

  // Address and data offered together, each dropped on its own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready) && n < 50);
    bready <= 1'b0;
    r = bresp;
    tmo(n);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready) && n < 50);
    rready <= 1'b0;
    v = rdata;
    r = rresp;
    tmo(n);
  endtask : rd

  function automatic logic [31:0] cw(input logic [1:0] op, input logic b,
      input logic l, input logic [2:0] s, input logic [2:0] d,
      input logic p, input logic [1:0] f);
    return {19'h0, f, p, d, s, l, b, op};
  endfunction : cw

  task automatic sw(input logic [2:0] i, input logic [15:0] d);
    wr({`FILE_BASE, i, 2'h0}, {16'h0, d});
  endtask : sw

  task automatic ck(input logic [2:0] i, input logic [15:0] e);
    rd({`FILE_BASE, i, 2'h0});
    `CHK("store word", e, v[15:0])
  endtask : ck

  task automatic cf(input logic [7:0] e);
    rd(`FLAGS_OFS);
    `CHK("flags", e, v[7:0])
  endtask : cf

  // Waits on the interrupt, so the mask must enable both status bits
  task automatic go(input logic [31:0] c, input logic e);
    int n;
    n = 0;
    wr(`CTRL_OFS, c | 32'h80000000);
    while (irq !== 1'b1 && n < 50) begin
      @(posedge aclk);
      n++;
    end
    rd(`STATUS_OFS);
    `CHK("illegal bit", e, v[`ST_ILLEGAL])
    while (irq !== 1'b0 && n < 50) begin
      @(posedge aclk);
      n++;
    end
    tmo(n);
  endtask : go

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic s_reset;
    cf(`FLAGS_RST);
    rd(`MASK_OFS);
    `CHK("mask", 32'h0, v)
    rd(8'h18);
    `CHK("unmapped resp", `RESP_DECERR, r)
    wr(`MASK_OFS, 32'h3);
    `CHK("mask write resp", `RESP_OKAY, r)
  endtask : s_reset

  task automatic s_arith;
    sw(3'h0, 16'h7fff);
    sw(3'h1, 16'h0001);
    wr(`FLAGS_OFS, 32'h53);
    go(cw(2'h0, 1'b0, 1'b0, 3'h1, 3'h0, 1'b0, 2'h0), 1'b0);
    ck(3'h0, 16'h8001);
    cf(8'h7a);
    rd(`RESULT_OFS);
    `CHK("result", 16'h8001, v[15:0])
    sw(3'h0, 16'h12ff);
    wr(`FLAGS_OFS, 32'h01);
    go(cw(2'h1, 1'b1, 1'b0, 3'h0, 3'h0, 1'b0, 2'h0), 1'b0);
    ck(3'h0, 16'h1200);
    cf(8'h05);
    sw(3'h0, 16'hffff);
    wr(`FLAGS_OFS, 32'h01);
    go(cw(2'h2, 1'b0, 1'b0, 3'h1, 3'h0, 1'b0, 2'h0), 1'b0);
    ck(3'h0, 16'h0000);
    cf(8'h05);
  endtask : s_arith

  task automatic s_mixed;
    sw(3'h0, 16'h00f0);
    sw(3'h4, 16'h0020);
    wr(`FLAGS_OFS, 32'h00);
    go(cw(2'h2, 1'b1, 1'b0, 3'h0, 3'h4, 1'b0, 2'h0), 1'b0);
    ck(3'h4, 16'h0110);
    sw(3'h0, 16'h3480);
    sw(3'h4, 16'h1285);
    go(cw(2'h2, 1'b1, 1'b0, 3'h4, 3'h0, 1'b0, 2'h0), 1'b0);
    ck(3'h0, 16'h3405);
    cf(8'h21);
  endtask : s_mixed

  // Stack pointer chosen by the user-stack flag, byte literal widened
  task automatic s_stack;
    sw(`USP_IDX, 16'h0100);
    sw(`ISP_IDX, 16'h0000);
    wr(`LIT_OFS, 32'h00fe);
    wr(`FLAGS_OFS, 32'h80);
    go(cw(2'h2, 1'b1, 1'b1, 3'h0, 3'h0, 1'b1, 2'h0), 1'b0);
    ck(`USP_IDX, 16'h00fe);
    ck(`ISP_IDX, 16'h0000);
    cf(8'h81);
    wr(`FLAGS_OFS, 32'h00);
    go(cw(2'h2, 1'b1, 1'b1, 3'h0, 3'h0, 1'b1, 2'h0), 1'b0);
    ck(`ISP_IDX, 16'hfffe);
    go(cw(2'h2, 1'b0, 1'b0, 3'h0, 3'h0, 1'b1, 2'h0), 1'b1);
    ck(`ISP_IDX, 16'hfffe);
  endtask : s_stack

  task automatic s_quick;
    sw(3'h1, 16'h0005);
    wr(`LIT_OFS, 32'h0008);
    wr(`FLAGS_OFS, 32'h00);
    go(cw(2'h2, 1'b0, 1'b1, 3'h0, 3'h1, 1'b0, 2'h1), 1'b0);
    ck(3'h1, 16'hfffd);
    cf(8'h08);
  endtask : s_quick

  task automatic s_illegal;
    sw(3'h0, 16'h1111);
    sw(3'h5, 16'h2222);
    go(cw(2'h2, 1'b1, 1'b0, 3'h4, 3'h5, 1'b0, 2'h0), 1'b1);
    ck(3'h5, 16'h2222);
    go(cw(2'h2, 1'b0, 1'b0, 3'h1, 3'h0, 1'b0, 2'h2), 1'b1);
    go(cw(2'h2, 1'b1, 1'b0, 3'h0, 3'h0, 1'b0, 2'h2), 1'b1);
    ck(3'h0, 16'h1111);
  endtask : s_illegal

  // Masked completion must stay off the interrupt line
  task automatic s_mask;
    wr(`MASK_OFS, 32'h0);
    wr(`CTRL_OFS, cw(2'h2, 1'b0, 1'b0, 3'h1, 3'h0, 1'b0, 2'h0) | 32'h80000000);
    repeat (10) @(posedge aclk);
    `CHK("masked irq", 1'b0, irq)
    rd(`STATUS_OFS);
    `CHK("done bit", 1'b1, v[`ST_DONE])
    rd(`STATUS_OFS);
    `CHK("done cleared", 1'b0, v[`ST_DONE])
  endtask : s_mask

  initial begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    s_reset();
    s_arith();
    s_mixed();
    s_stack();
    s_quick();
    s_illegal();
    s_mask();
    close_out();
  end
endmodule : testbench
